// ---- core/srs_slave.sv ----
// Purpose: Serial slave giving a master read and write access to 32 registers.
// Assumes: Serial clock well below clock/6; mode polarity 1, phase 1.
// Notes:   Register file is outside; this block issues reads and commits writes.
//
// Functional notes
// - Clock idles high; shift falling, sample rising.
// - Select low frames transfer; high idles logic.
// - Frame is command byte then data bytes.
// - Status byte returned during command byte.
// - Status byte bit order signature down to transceiver.
// - Burst bit ignored on writes.
// - Write data byte returns readback pointer register.
// - Write valid only with exactly sixteen clocks.
// - Write commits at select rising edge only.
// - Read bytes continue while select low, clocking.
// - No burst: same register resampled each byte.
// - Burst: address increments after each byte.
module srs_slave
  import srs_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = srs_pkg::ADDR_W
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  input  wire logic                        serial_clk,
  input  wire logic                        slave_select_low,
  input  wire logic                        mosi,
  output logic                             miso,
  output logic                             miso_oe,
  input  wire logic                        access_signature_bit,
  input  wire logic                        conversion_done_flag,
  input  wire logic                        threshold_hit_flag,
  input  wire logic                        bridge_overcurrent_flag,
  input  wire logic                        highside_overcurrent_flag,
  input  wire logic                        mirror_driver_overcurrent_flag,
  input  wire logic                        supply_fault_flag,
  input  wire logic                        bus_transceiver_flag,
  input  wire logic [srs_pkg::ADDR_W-1:0]  readback_pointer,
  output logic      [srs_pkg::ADDR_W-1:0]  rd_addr,
  input  wire logic [srs_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                        rd_addr_valid,
  output logic                             wr_strobe,
  output logic      [srs_pkg::ADDR_W-1:0]  wr_addr,
  output logic      [srs_pkg::DATA_W-1:0]  wr_data,
  output logic                             frame_busy
);
  import srs_pkg::*;

  if (ADDR_WIDTH != ADDR_W) begin : g_bad_width
    $error("srs_slave supports only the 5-bit address space.");
  end

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;

  srs_sync u_sync_sclk (
    .clock       (clock),
    .arst_n      (arst_n),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (serial_clk),
    .sync_out    (sclk_s)
  );
  srs_sync u_sync_cs (
    .clock       (clock),
    .arst_n      (arst_n),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (slave_select_low),
    .sync_out    (cs_n_s)
  );
  srs_sync u_sync_mosi (
    .clock       (clock),
    .arst_n      (arst_n),
    .clk_en      (clk_en),
    .reset_value (1'b1),
    .async_in    (mosi),
    .sync_out    (mosi_s)
  );

  srs_state_t             state_reg;
  srs_state_t             state_next;
  logic                   sclk_d_reg;
  logic                   cs_d_reg;
  logic [BIT_CNT_W-1:0]   cnt_reg;
  logic [BIT_CNT_W-1:0]   cnt_next;
  logic                   over_reg;
  logic                   over_next;
  logic [DATA_W-1:0]      rx_reg;
  logic [DATA_W-1:0]      rx_next;
  logic [DATA_W-1:0]      tx_reg;
  logic [DATA_W-1:0]      tx_next;
  logic [ADDR_W-1:0]      addr_reg;
  logic [ADDR_W-1:0]      addr_next;
  logic                   burst_reg;
  logic                   burst_next;
  logic [DATA_W-1:0]      wdat_reg;
  logic [DATA_W-1:0]      wdat_next;
  logic                   miso_reg;
  logic                   miso_next;
  logic                   wr_reg;
  logic                   wr_next;
  logic [ADDR_W-1:0]      wa_reg;
  logic [ADDR_W-1:0]      wa_next;
  logic [DATA_W-1:0]      wd_reg;
  logic [DATA_W-1:0]      wd_next;

  logic              rise;
  logic              fall;
  logic              cs_fall;
  logic              cs_rise;
  logic [DATA_W-1:0] status_byte;
  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] rd_safe;

  assign rise    = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign fall    = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_d_reg;
  assign cs_rise = cs_n_s & ~cs_d_reg;
  assign rx_shift = {rx_reg[DATA_W-2:0], mosi_s};
  assign rd_safe  = rd_addr_valid ? rd_data : BYTE_ZERO;
  assign status_byte = {access_signature_bit, conversion_done_flag,
                        threshold_hit_flag, bridge_overcurrent_flag,
                        highside_overcurrent_flag, mirror_driver_overcurrent_flag,
                        supply_fault_flag, bus_transceiver_flag};

  always_comb begin
    // The read port points at the source of the next outgoing byte. On the last command
    // bit a read already selects its own address, so its first data byte is not stale.
    rd_addr = addr_reg;
    if (state_reg == SRS_CMD) begin
      if (rx_shift[CMD_RW_BIT]) begin
        rd_addr = rx_shift[CMD_ADDR_MSB:CMD_ADDR_LSB];
      end else begin
        rd_addr = readback_pointer;
      end
    end else if (state_reg == SRS_RDATA && burst_reg) begin
      rd_addr = addr_reg + ADDR_W'(1);
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    over_next  = over_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    addr_next  = addr_reg;
    burst_next = burst_reg;
    wdat_next  = wdat_reg;
    miso_next  = miso_reg;
    wr_next    = 1'b0;
    wa_next    = wa_reg;
    wd_next    = wd_reg;
    if (cs_fall) begin
      // Status byte is captured at frame start; first bit leaves at once.
      state_next = SRS_CMD;
      cnt_next   = '0;
      over_next  = 1'b0;
      tx_next    = status_byte;
      miso_next  = status_byte[DATA_W-1];
    end else if (cs_rise) begin
      // Commit only a complete two-byte write, and only now.
      if (state_reg == SRS_WDATA && cnt_reg == BIT_CNT_W'(WRITE_FRAME_BITS) && !over_reg) begin
        wr_next = 1'b1;
        wa_next = addr_reg;
        wd_next = wdat_reg;
      end
      state_next = SRS_IDLE;
    end else if (rise && state_reg != SRS_IDLE) begin
      rx_next = rx_shift;
      // The count runs on past 16 so byte boundaries stay visible in long reads.
      // The sticky flag remembers that a write frame went too long.
      if (cnt_reg == BIT_CNT_W'(WRITE_FRAME_BITS)) begin
        over_next = 1'b1;
      end
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg[2:0] == 3'd7) begin
        case (state_reg)
          SRS_CMD: begin
            addr_next  = rx_shift[CMD_ADDR_MSB:CMD_ADDR_LSB];
            burst_next = rx_shift[CMD_BURST_BIT];
            if (rx_shift[CMD_RW_BIT]) begin
              state_next = SRS_RDATA;
            end else begin
              state_next = SRS_WDATA;
            end
            tx_next = rd_safe;
          end
          SRS_WDATA: begin
            wdat_next = rx_shift;
            over_next = over_reg | (cnt_reg != BIT_CNT_W'(WRITE_FRAME_BITS - 1));
            tx_next   = BYTE_ZERO;
          end
          SRS_RDATA: begin
            // Next byte: same address resampled, or the following one.
            if (burst_reg) begin
              addr_next = addr_reg + 1'b1;
            end
            tx_next = rd_safe;
          end
          default: begin
            state_next = SRS_IDLE;
          end
        endcase
      end else begin
        tx_next = {tx_reg[DATA_W-2:0], 1'b0};
      end
    end else if (fall && state_reg != SRS_IDLE && !(state_reg == SRS_CMD && cnt_reg == '0)) begin
      // The first falling edge of a frame finds the status bit already on the line.
      miso_next = tx_reg[DATA_W-1];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= SRS_IDLE;
      sclk_d_reg <= 1'b1;
      cs_d_reg   <= 1'b1;
      cnt_reg    <= '0;
      over_reg   <= 1'b0;
      rx_reg     <= BYTE_ZERO;
      tx_reg     <= BYTE_ZERO;
      addr_reg   <= PTR_RESET;
      burst_reg  <= 1'b0;
      wdat_reg   <= BYTE_ZERO;
      miso_reg   <= 1'b0;
      wr_reg     <= 1'b0;
      wa_reg     <= '0;
      wd_reg     <= BYTE_ZERO;
    end else if (clk_en) begin
      state_reg  <= state_next;
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_n_s;
      cnt_reg    <= cnt_next;
      over_reg   <= over_next;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      addr_reg   <= addr_next;
      burst_reg  <= burst_next;
      wdat_reg   <= wdat_next;
      miso_reg   <= miso_next;
      wr_reg     <= wr_next;
      wa_reg     <= wa_next;
      wd_reg     <= wd_next;
    end
  end

  assign miso       = miso_reg;
  assign miso_oe    = ~cs_n_s;
  assign wr_strobe  = wr_reg;
  assign wr_addr    = wa_reg;
  assign wr_data    = wd_reg;
  assign frame_busy = (state_reg != SRS_IDLE);
endmodule

// ---- core/srs_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock.
// Notes:   Output changes only when stages two and three agree.
module srs_sync (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic reset_value,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       out_reg;
  logic       out_next;

  always_comb begin
    stage_next = {stage_reg[1:0], async_in};
    out_next   = out_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];
    end
  end

  // The first stage only feeds the second; reset always loads ones, and the reset_value port is unused.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 3'b111;
      out_reg   <= 1'b1;
    end else if (clk_en) begin
      stage_reg <= stage_next;
      out_reg   <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule

// ---- inc/srs_pkg.sv ----
// Purpose: Constants for the serial register access slave.
// Assumes: Byte-framed serial link, clock idles high, mode 1/1.
// Notes:   Register contents and flag sources live outside this block.
package srs_pkg;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CMD_RW_BIT   = 7;
  localparam int unsigned CMD_ADDR_MSB = 6;
  localparam int unsigned CMD_ADDR_LSB = 2;
  localparam int unsigned CMD_BURST_BIT = 1;
  localparam int unsigned WRITE_FRAME_BITS = 16;
  localparam int unsigned BIT_CNT_W    = 5;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam logic [ADDR_W-1:0] PTR_RESET = 5'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    SRS_IDLE  = 2'b00,
    SRS_CMD   = 2'b01,
    SRS_WDATA = 2'b11,
    SRS_RDATA = 2'b10
  } srs_state_t;
endpackage

// ---- tb/srs_chk.sv ----
// Purpose: Port-level checks of the serial register access slave.
// Assumes: clk_en is held high by the bench.
// Notes:   Windows allow for the three-stage input synchronisers and their output flop.
module srs_chk
  import srs_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       arst_n,
  input wire logic                       serial_clk,
  input wire logic                       slave_select_low,
  input wire logic                       miso,
  input wire logic                       miso_oe,
  input wire logic                       wr_strobe,
  input wire logic [srs_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [srs_pkg::DATA_W-1:0] wr_data,
  input wire logic                       frame_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_bit_held;
    (serial_clk && !slave_select_low) [*8];
  endsequence
  property p_miso_held;
    s_bit_held |-> $stable(miso);
  endproperty
  a_miso_held: assert property (p_miso_held)
    else $error("miso moved while serial clock high");
  property p_busy_starts;
    $fell(slave_select_low) |-> ##[1:8] frame_busy;
  endproperty
  a_busy_starts: assert property (p_busy_starts)
    else $error("frame_busy missing after select fall");
  property p_busy_cause;
    $rose(frame_busy) |-> !slave_select_low;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("frame_busy rose without select");
  property p_oe_ends;
    $rose(slave_select_low) |-> ##[1:8] !miso_oe;
  endproperty
  a_oe_ends: assert property (p_oe_ends)
    else $error("miso_oe still high after select rise");
  property p_oe_cause;
    $rose(miso_oe) |-> !slave_select_low;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("miso_oe rose without select");
  property p_strobe_pulse;
    wr_strobe |=> !wr_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("wr_strobe longer than one cycle");
  property p_strobe_late;
    $rose(wr_strobe) |-> slave_select_low && !frame_busy;
  endproperty
  a_strobe_late: assert property (p_strobe_late)
    else $error("write committed inside frame");
  property p_wr_held;
    !wr_strobe |-> $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_wr_held: assert property (p_wr_held)
    else $error("write outputs moved without strobe");
endmodule

// ---- tb/srs_master.sv ----
// Purpose: Serial master model driving the slave's link pins.
// Assumes: Pull-ups on select and clock, pull-down on data.
// Notes:   The clock stands high between frames, as the real master does.
module srs_master (
  output logic      serial_clk,
  output logic      slave_select_low,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk = 1'b1;
    slave_select_low = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    slave_select_low = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b0;
      mosi = tx[39-i];
      #80;
      serial_clk = 1'b1;
      rx[39-i] = miso;
      #80;
    end
    mosi = 1'b0;
    slave_select_low = 1'b1;
    #160;
  endtask
endmodule

// ---- tb/test_spi_register_access_slave.sv ----
// Purpose: Self-checking bench for the serial register access slave.
// Assumes: Addresses 28 to 31 are unimplemented in the bench register file.
// Notes:   Flags change only between frames, since the slave samples them at frame start.
module test_spi_register_access_slave;
  import srs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic       serial_clk, slave_select_low, mosi, miso, miso_oe, wr_strobe, frame_busy;
  logic       miso_pin;
  logic [7:0] flags, wr_data;
  logic [7:0] regs [32];
  logic [7:0] exp_mem [32];
  logic [4:0] ptr, rd_addr, wr_addr;
  logic [39:0] rx;
  int         err_count = 0, compares = 0, strobes = 0, cycles = 0;
  // Released pin shows the inverse so a dropped enable corrupts the data seen.
  assign miso_pin = miso_oe ? miso : !miso;
  srs_slave dut_u (.clock, .arst_n, .clk_en(1'b1), .serial_clk, .slave_select_low, .mosi,
    .miso, .miso_oe, .access_signature_bit(flags[7]), .conversion_done_flag(flags[6]),
    .threshold_hit_flag(flags[5]), .bridge_overcurrent_flag(flags[4]),
    .highside_overcurrent_flag(flags[3]), .mirror_driver_overcurrent_flag(flags[2]),
    .supply_fault_flag(flags[1]), .bus_transceiver_flag(flags[0]), .readback_pointer(ptr),
    .rd_addr, .rd_data(regs[rd_addr]), .rd_addr_valid(rd_addr < 5'h1c), .wr_strobe,
    .wr_addr, .wr_data, .frame_busy);
  srs_master m_u (.serial_clk, .slave_select_low, .mosi, .miso(miso_pin));
  initial forever #2.5 clock = ~clock;
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (wr_strobe === 1'b1) begin
      regs[wr_addr] <= wr_data;
      strobes <= strobes + 1;
    end
    if (cycles == 50000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] rd_exp(logic [4:0] a);
    return (a < 5'h1c) ? exp_mem[a] : 8'h00;
  endfunction
  task automatic frame(int n, logic [39:0] tx);
    m_u.xfer(n, tx, rx);
    repeat (10) @(posedge clock);
    #1;
  endtask
  initial begin
    logic [4:0] a;
    logic [7:0] d, st;
    logic       b;
    int         n0;
    flags = 8'h00;
    ptr = 5'h01;
    void'($urandom(32'h0000_406d));
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'($urandom);
      exp_mem[i] = regs[i];
    end
    repeat (8) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 5'h1f : 5'($urandom);
      d = 8'($urandom);
      b = 1'($urandom);
      flags = 8'($urandom);
      ptr = 5'($urandom);
      st = rd_exp(ptr);
      frame(16, {1'b0, a, b, 1'b0, d, 24'h00_0000});
      chk("status", flags, rx[39:32]);
      chk("readback", st, rx[31:24]);
      chk("stored", d, regs[a]);
      exp_mem[a] = d;
      n0 = strobes;
      frame((i % 2) ? 17 : 15, {1'b0, a, 2'b00, ~d, 24'h00_0000});
      chk("refused", 8'(n0), 8'(strobes));
      chk("kept", d, regs[a]);
    end
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? 5'h1e : 5'($urandom);
      b = 1'(i);
      flags = 8'($urandom);
      frame(40, {1'b1, a, b, 1'b0, 32'h0000_0000});
      chk("status", flags, rx[39:32]);
      for (int k = 0; k < 4; k++) begin
        chk("read", rd_exp(b ? a + 5'(k) : a), rx[31-8*k -: 8]);
        // The line above also and through the burst wrap case.
      end
    end
    print_verdict();
  end
endmodule
bind srs_slave srs_chk chk_u (.clock, .arst_n, .serial_clk, .slave_select_low, .miso,
  .miso_oe, .wr_strobe, .wr_addr, .wr_data, .frame_busy);
